// ===== verilog/mcj_defines.svh
// How it works
// [RULE1] Entry jump loads PC from code-address field
// [RULE2] Named modifier adds its register to target
// [RULE3] Entry jump target outside block raises error
// [RULE4] Entry call saves PC plus one, then jumps
// [RULE5] Local call saves PC plus one, stays in section
// [RULE6] Return address sits in low 20 link bits
// [RULE7] No link register named means register zero
// [RULE8] Either call inside hardware loop raises error
// [RULE9] Call target outside program block raises error
// [RULE10] Signed low multiply keeps low product half
// [RULE11] Checked multiply flags high half not sign
// [RULE12] Wide multiply puts high half one below
// [RULE13] Wide multiply refuses register zero as operand
// [RULE14] Destination field is first operand and result
// [RULE15] Return loads low 20 bits plus offset
// [RULE16] Multiply stalls issue until results are written
`ifndef MCJ_DEFINES_SVH
`define MCJ_DEFINES_SVH

// Bus geometry
`define MCJ_AW 8
`define MCJ_NREG 14
`define MCJ_LAST_REG 4'hD

// Register byte addresses
`define MCJ_OFF_INSTR 8'h00
`define MCJ_OFF_PC 8'h04
`define MCJ_OFF_PB_LO 8'h08
`define MCJ_OFF_PB_HI 8'h0C
`define MCJ_OFF_SEC_LO 8'h10
`define MCJ_OFF_SEC_HI 8'h14
`define MCJ_OFF_CTRL 8'h18
`define MCJ_OFF_STATUS 8'h1C
`define MCJ_OFF_MASK 8'h20
`define MCJ_OFF_FLAGS 8'h24
`define MCJ_OFF_MREG 8'h40
`define MCJ_OFF_MREG_END 8'h78

// Instruction word fields
`define MCJ_OP_HI 31
`define MCJ_OP_LO 28
`define MCJ_DST_HI 27
`define MCJ_DST_LO 24
`define MCJ_SRC_HI 23
`define MCJ_SRC_LO 20
`define MCJ_CA_HI 19
`define MCJ_CA_LO 0

// Operation codes
`define MCJ_OPC_JUMP 4'h1
`define MCJ_OPC_ECALL 4'h2
`define MCJ_OPC_LCALL 4'h3
`define MCJ_OPC_MUL_LOW 4'h4
`define MCJ_OPC_MUL_CHK 4'h5
`define MCJ_OPC_MUL_WIDE 4'h6
`define MCJ_OPC_RETURN 4'h7

// Status and control bits
`define MCJ_ST_ERR 0
`define MCJ_ST_DONE 1
`define MCJ_ST_OVF 2
`define MCJ_FL_V 0
`define MCJ_FL_BUSY 1
`define MCJ_CTRL_LOOP 0

// Reset values
`define MCJ_RST_PC 20'h00000
`define MCJ_RST_PB_HI 20'hFFFFF
`define MCJ_RST_SEC_HI 20'hFFFFF

// Bus answers
`define MCJ_RESP_OKAY 2'h0
`define MCJ_RESP_SLVERR 2'h2

`endif

// ===== verilog/mcj_pkg.sv
`include "mcj_defines.svh"

package mcj_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {MCJ_IDLE, MCJ_EXEC, MCJ_MUL} mcj_fsm_t;

  // Decoded instruction word
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] dst;
    logic [3:0] src;
    logic [19:0] ca;
  } mcj_instr_t;

  // Whole state of the block
  typedef struct packed {
    logic [`MCJ_NREG-1:0][31:0] m;
    logic [19:0] pc;
    logic [19:0] pb_lo;
    logic [19:0] pb_hi;
    logic [19:0] sec_lo;
    logic [19:0] sec_hi;
    logic loop_act;
    logic vflag;
    logic [2:0] st;
    logic [2:0] mask;
    mcj_instr_t ir;
    logic [63:0] prod;
    mcj_fsm_t fsm;
    logic aw_ok;
    logic [`MCJ_AW-1:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcj_state_t;

endpackage

// ===== verilog/mcj_core.sv
`timescale 1ns/1ps
`include "mcj_defines.svh"

module mcj_core
  import mcj_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`MCJ_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`MCJ_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic irq
);

  // Registered and next state
  mcj_state_t s_q;
  mcj_state_t s_d;

  // Decode of the held instruction
  logic [3:0] ex_op;
  logic [3:0] ex_d;
  logic [3:0] ex_s;
  logic [3:0] ex_dm1;
  logic [19:0] ex_ca;
  logic sel_ok;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [63:0] mul_full;
  logic ovf_now;
  logic [19:0] jmp_tgt;
  logic [19:0] ret_tgt;
  logic [19:0] link_val;
  logic busy;

  // Byte-lane merge for register writes
  function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] wd,
                                      input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bounds check against a low/high pair, both inclusive
  function automatic logic outside(input logic [19:0] a, input logic [19:0] lo,
                                   input logic [19:0] hi);
    return (a < lo) || (a > hi);
  endfunction

  // Field split of the instruction register
  assign ex_op = s_q.ir.op;
  assign ex_d = s_q.ir.dst;
  assign ex_s = s_q.ir.src;
  assign ex_dm1 = ex_d - 4'h1;
  assign ex_ca = s_q.ir.ca;
  assign sel_ok = (ex_d <= `MCJ_LAST_REG) && (ex_s <= `MCJ_LAST_REG);
  assign busy = (s_q.fsm != MCJ_IDLE);

  // Operand fetch: destination field is first operand, second field the other
  assign opa = (ex_d <= `MCJ_LAST_REG) ? s_q.m[ex_d] : 32'h00000000; // RULE14
  assign opb = (ex_s <= `MCJ_LAST_REG) ? s_q.m[ex_s] : 32'h00000000; // RULE14

  // Signed 32x32 product; operands widened first so no high bits are lost
  assign mul_full = $signed({{32{opa[31]}}, opa}) * $signed({{32{opb[31]}}, opb}); // RULE10
  // Overflow when any high bit differs from the low half's sign bit
  assign ovf_now = |(mul_full[63:32] ^ {32{mul_full[31]}}); // RULE11

  // Jump target, with modifier register added when one is named
  assign jmp_tgt = (ex_s != 4'h0) ? ex_ca + opb[19:0] : ex_ca; // RULE1 RULE2
  // Return target from the low 20 bits of the register plus offset
  assign ret_tgt = opa[19:0] + ex_ca; // RULE15
  // Return address saved by both call forms
  assign link_val = s_q.pc + 20'h00001; // RULE4 RULE5

  // Bus handshakes come straight from the state
  assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Level interrupt while any unmasked sticky bit is set
  assign irq = |(s_q.st & s_q.mask);

  // Next-state logic: bus slave, register file and sequencer
  always_comb begin
    logic [2:0] st_set;
    logic [2:0] st_clr;
    logic [31:0] wv;
    logic [3:0] widx;
    logic [3:0] ridx;
    st_set = 3'h0;
    st_clr = 3'h0;
    wv = 32'h00000000;
    widx = 4'h0;
    ridx = 4'h0;
    s_d = s_q;

    // Capture write address and write data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_ok = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_ok = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end

    // Commit a write once both halves are held
    if (s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `MCJ_RESP_OKAY;
      wv = s_q.wdata;
      widx = 4'((s_q.awaddr - `MCJ_OFF_MREG) >> 2);
      if (busy && (s_q.awaddr != `MCJ_OFF_STATUS) && (s_q.awaddr != `MCJ_OFF_MASK)) begin
        // No issue or state change while an operation runs, except status and mask writes
        s_d.bresp = `MCJ_RESP_SLVERR; // RULE16
      end else begin
        case (s_q.awaddr)
          `MCJ_OFF_INSTR: begin
            s_d.ir = mcj_instr_t'(mrg(32'h00000000, wv, s_q.wstrb));
            s_d.fsm = MCJ_EXEC;
          end
          `MCJ_OFF_PC: begin
            s_d.pc = 20'(mrg({12'h000, s_q.pc}, wv, s_q.wstrb));
          end
          `MCJ_OFF_PB_LO: begin
            s_d.pb_lo = 20'(mrg({12'h000, s_q.pb_lo}, wv, s_q.wstrb));
          end
          `MCJ_OFF_PB_HI: begin
            s_d.pb_hi = 20'(mrg({12'h000, s_q.pb_hi}, wv, s_q.wstrb));
          end
          `MCJ_OFF_SEC_LO: begin
            s_d.sec_lo = 20'(mrg({12'h000, s_q.sec_lo}, wv, s_q.wstrb));
          end
          `MCJ_OFF_SEC_HI: begin
            s_d.sec_hi = 20'(mrg({12'h000, s_q.sec_hi}, wv, s_q.wstrb));
          end
          `MCJ_OFF_CTRL: begin
            if (s_q.wstrb[0]) begin
              s_d.loop_act = wv[`MCJ_CTRL_LOOP];
            end
          end
          `MCJ_OFF_STATUS: begin
            // Write one to clear
            if (s_q.wstrb[0]) begin
              st_clr = wv[2:0];
            end
          end
          `MCJ_OFF_MASK: begin
            if (s_q.wstrb[0]) begin
              s_d.mask = wv[2:0];
            end
          end
          default: begin
            if ((s_q.awaddr >= `MCJ_OFF_MREG) && (s_q.awaddr < `MCJ_OFF_MREG_END)
                && (s_q.awaddr[1:0] == 2'h0)) begin
              s_d.m[widx] = mrg(s_q.m[widx], wv, s_q.wstrb);
            end else begin
              // Unmapped or read-only address
              s_d.bresp = `MCJ_RESP_SLVERR;
            end
          end
        endcase
      end
    end

    // Write answer leaves when taken
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read: data registered one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `MCJ_RESP_OKAY;
      s_d.rdata = 32'h00000000;
      ridx = 4'((s_axi_araddr - `MCJ_OFF_MREG) >> 2);
      case (s_axi_araddr)
        `MCJ_OFF_INSTR: s_d.rdata = s_q.ir;
        `MCJ_OFF_PC: s_d.rdata = {12'h000, s_q.pc};
        `MCJ_OFF_PB_LO: s_d.rdata = {12'h000, s_q.pb_lo};
        `MCJ_OFF_PB_HI: s_d.rdata = {12'h000, s_q.pb_hi};
        `MCJ_OFF_SEC_LO: s_d.rdata = {12'h000, s_q.sec_lo};
        `MCJ_OFF_SEC_HI: s_d.rdata = {12'h000, s_q.sec_hi};
        `MCJ_OFF_CTRL: s_d.rdata = {31'h00000000, s_q.loop_act};
        `MCJ_OFF_STATUS: s_d.rdata = {29'h00000000, s_q.st};
        `MCJ_OFF_MASK: s_d.rdata = {29'h00000000, s_q.mask};
        `MCJ_OFF_FLAGS: s_d.rdata = {30'h00000000, busy, s_q.vflag};
        default: begin
          if ((s_axi_araddr >= `MCJ_OFF_MREG) && (s_axi_araddr < `MCJ_OFF_MREG_END)
              && (s_axi_araddr[1:0] == 2'h0)) begin
            s_d.rdata = s_q.m[ridx];
          end else begin
            s_d.rresp = `MCJ_RESP_SLVERR;
          end
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Sequencer
    case (s_q.fsm)
      MCJ_IDLE: begin
      end
      MCJ_EXEC: begin
        s_d.fsm = MCJ_IDLE;
        st_set[`MCJ_ST_DONE] = 1'b1;
        if (!sel_ok) begin
          // Register select beyond the last general register
          st_set[`MCJ_ST_ERR] = 1'b1;
        end else begin
          case (ex_op)
            `MCJ_OPC_JUMP: begin
              if (outside(jmp_tgt, s_q.pb_lo, s_q.pb_hi)) begin
                st_set[`MCJ_ST_ERR] = 1'b1; // RULE3
              end else begin
                s_d.pc = jmp_tgt; // RULE1 RULE2
              end
            end
            `MCJ_OPC_ECALL: begin
              if (s_q.loop_act || outside(ex_ca, s_q.pb_lo, s_q.pb_hi)) begin
                st_set[`MCJ_ST_ERR] = 1'b1; // RULE8 RULE9
              end else begin
                // Link written alongside the PC load; upper bits cleared
                s_d.m[ex_d] = {12'h000, link_val}; // RULE4 RULE6 RULE7
                s_d.pc = ex_ca; // RULE4
              end
            end
            `MCJ_OPC_LCALL: begin
              if (s_q.loop_act || outside(ex_ca, s_q.pb_lo, s_q.pb_hi)
                  || outside(ex_ca, s_q.sec_lo, s_q.sec_hi)) begin
                st_set[`MCJ_ST_ERR] = 1'b1; // RULE5 RULE8 RULE9
              end else begin
                s_d.m[ex_d] = {12'h000, link_val}; // RULE5 RULE6 RULE7
                s_d.pc = ex_ca; // RULE5
              end
            end
            `MCJ_OPC_RETURN: begin
              if (outside(ret_tgt, s_q.pb_lo, s_q.pb_hi)) begin
                st_set[`MCJ_ST_ERR] = 1'b1;
              end else begin
                s_d.pc = ret_tgt; // RULE15
              end
            end
            `MCJ_OPC_MUL_LOW, `MCJ_OPC_MUL_CHK: begin
              // Product held, written next cycle while issue stays closed
              s_d.prod = mul_full; // RULE10 RULE16
              s_d.fsm = MCJ_MUL;
              st_set[`MCJ_ST_DONE] = 1'b0;
            end
            `MCJ_OPC_MUL_WIDE: begin
              if (ex_d == 4'h0) begin
                st_set[`MCJ_ST_ERR] = 1'b1; // RULE13
              end else begin
                s_d.prod = mul_full; // RULE16
                s_d.fsm = MCJ_MUL;
                st_set[`MCJ_ST_DONE] = 1'b0;
              end
            end
            default: begin
              // Unknown operation code
              st_set[`MCJ_ST_ERR] = 1'b1;
            end
          endcase
        end
      end
      MCJ_MUL: begin
        s_d.fsm = MCJ_IDLE;
        st_set[`MCJ_ST_DONE] = 1'b1;
        s_d.m[ex_d] = s_q.prod[31:0]; // RULE10 RULE14
        if (ex_op == `MCJ_OPC_MUL_CHK) begin
          s_d.vflag = |(s_q.prod[63:32] ^ {32{s_q.prod[31]}}); // RULE11
          st_set[`MCJ_ST_OVF] = s_d.vflag;
        end
        if (ex_op == `MCJ_OPC_MUL_WIDE) begin
          s_d.m[ex_dm1] = s_q.prod[63:32]; // RULE12
        end
      end
      default: begin
        s_d.fsm = MCJ_IDLE;
      end
    endcase

    // Sticky status: a new event wins over a clear
    s_d.st = (s_q.st & ~st_clr) | st_set;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.pc <= `MCJ_RST_PC;
      s_q.pb_hi <= `MCJ_RST_PB_HI;
      s_q.sec_hi <= `MCJ_RST_SEC_HI;
      s_q.fsm <= MCJ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Entry jump without modifier lands on the code address
  jump_load_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_JUMP && sel_ok && ex_s == 4'h0
     && !outside(ex_ca, s_q.pb_lo, s_q.pb_hi)) |=> (s_q.pc == $past(ex_ca)))
    else $error("entry jump did not load the code address");

  // Modifier register is added to the code address
  jump_mod_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_JUMP && sel_ok && ex_s != 4'h0
     && !outside(jmp_tgt, s_q.pb_lo, s_q.pb_hi))
    |=> (s_q.pc == $past(ex_ca) + $past(opb[19:0])))
    else $error("modified jump target wrong");

  // Out-of-block jump flags an error and leaves the PC alone
  range_err_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_JUMP && sel_ok
     && outside(jmp_tgt, s_q.pb_lo, s_q.pb_hi))
    |=> (s_q.st[`MCJ_ST_ERR] && $stable(s_q.pc)))
    else $error("out-of-range jump not refused");

  // Call saves PC plus one in the low 20 link bits
  call_link_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_ECALL && sel_ok && !s_q.loop_act
     && !outside(ex_ca, s_q.pb_lo, s_q.pb_hi))
    |=> (s_q.m[$past(ex_d)][19:0] == $past(s_q.pc) + 20'h00001)
        && (s_q.pc == $past(ex_ca)))
    else $error("call link value or target wrong");

  // Calls inside a hardware loop are refused
  loop_call_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (s_q.fsm == MCJ_EXEC && sel_ok && s_q.loop_act
     && (ex_op == `MCJ_OPC_ECALL || ex_op == `MCJ_OPC_LCALL))
    |=> (s_q.st[`MCJ_ST_ERR] && $stable(s_q.pc)))
    else $error("call in loop not refused");

  // Low multiply result appears two edges after issue
  mul_low_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_MUL_LOW && sel_ok)
    |-> ##2 (s_q.m[$past(ex_d, 2)] == $past(mul_full[31:0], 2)))
    else $error("low product not written");

  // Overflow flag follows the high half against the sign
  ovf_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE11
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_MUL_CHK && sel_ok)
    |-> ##2 (s_q.vflag == $past(ovf_now, 2)))
    else $error("overflow flag wrong");

  // Wide multiply writes the high half one register below
  wide_pair_a: assert property (@(posedge clk) disable iff (rst) // RULE12
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_MUL_WIDE && sel_ok && ex_d != 4'h0)
    |-> ##2 (s_q.m[$past(ex_dm1, 2)] == $past(mul_full[63:32], 2)))
    else $error("wide high half misplaced");

  // Register zero as wide operand is refused at once
  wide_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE13
    (s_q.fsm == MCJ_EXEC && ex_op == `MCJ_OPC_MUL_WIDE && ex_d == 4'h0)
    |=> (s_q.st[`MCJ_ST_ERR] && s_q.fsm == MCJ_IDLE))
    else $error("wide multiply accepted register zero");

  // Busy holds while the product is written, then drops with done raised
  mul_stall_a: assert property (@(posedge clk) disable iff (rst) // RULE16
    (s_q.fsm == MCJ_MUL) |-> busy ##1 (!busy && s_q.st[`MCJ_ST_DONE]))
    else $error("multiply finished without done");

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "mcj_defines.svh"

module tb_top
  import mcj_pkg::*;
;
  // Bus and pin signals
  logic clk, rst, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [`MCJ_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Reference copy of the architectural state
  logic [31:0] mm [14];
  logic [19:0] pc_e, pb_lo, pb_hi, sec_lo, sec_hi;
  logic loop_e, v_e;
  logic [2:0] mask_e;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  mcj_core mcj_core_inst (
    .clk(clk), .rst(rst), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 40000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write cycle: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic fin;
    fin = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!fin) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        fin = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  // Read cycle
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic fin;
    fin = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!fin) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        fin = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // Write expecting an OKAY answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("write resp", {30'h0, r}, 32'h0);
  endtask

  // Read and compare
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(nm, d, e);
  endtask

  // Loads one general register and the reference copy
  task automatic setm(input int i, input logic [31:0] val);
    wr(8'(8'h40 + 4 * i), val);
    mm[i] = val;
  endtask

  // Target outside the program block
  function automatic logic out_blk(input logic [19:0] t);
    return (t < pb_lo) || (t > pb_hi);
  endfunction

  // Expected effect of one instruction; st is the expected status
  task automatic model(input logic [3:0] op, input logic [3:0] d, input logic [3:0] s,
                       input logic [19:0] ca, output logic [2:0] st);
    logic [19:0] t;
    logic [63:0] p;
    logic e;
    // A select past the last register is refused before decode
    e = (d > 4'hD) || (s > 4'hD);
    st = 3'b010;
    p = $signed(mm[d]) * $signed(mm[s]);
    case (e ? 4'h0 : op)
      4'h1: begin
        t = ca + ((s != 4'h0) ? mm[s][19:0] : 20'h0);
        e = out_blk(t);
        if (!e) pc_e = t;
      end
      4'h2, 4'h3: begin
        e = loop_e || out_blk(ca) || (op == 4'h3 && (ca < sec_lo || ca > sec_hi));
        if (!e) begin
          mm[d] = {12'h0, pc_e + 20'h1};
          pc_e = ca;
        end
      end
      4'h4, 4'h5: begin
        mm[d] = p[31:0];
        if (op == 4'h5) begin
          v_e = (p[63:32] !== {32{p[31]}});
          st[2] = v_e;
        end
      end
      4'h6: begin
        e = (d == 4'h0);
        if (!e) begin
          mm[d] = p[31:0];
          mm[d - 4'h1] = p[63:32];
        end
      end
      4'h7: begin
        t = mm[d][19:0] + ca;
        e = out_blk(t);
        if (!e) pc_e = t;
      end
      default: begin
        // Unknown code or bad select: error only
        e = 1'b1;
      end
    endcase
    st[0] = e;
  endtask

  // Issues one instruction, probes busy mid-flight, then checks all state
  task automatic exec(input logic [3:0] op, input logic [3:0] d, input logic [3:0] s,
                      input logic [19:0] ca);
    logic [31:0] rd;
    logic [1:0] r, r2;
    logic [2:0] st;
    int k;
    model(op, d, s, ca, st);
    fork
      axw(8'h00, {op, d, s, ca}, r);
      begin
        repeat (2) @(posedge clk);
        axr(8'h24, rd, r2);
      end
    join
    chk("issue resp", {30'h0, r}, 32'h0);
    chk("busy", rd & 32'h2, 32'h2);
    rd = 32'h0;
    k = 0;
    // Poll for completion, bounded
    while (rd[1] !== 1'b1 && k < 20) begin
      axr(8'h1C, rd, r2);
      k++;
    end
    chk("status", rd, {29'h0, st});
    chk("irq", {31'h0, irq}, {31'h0, |(st & mask_e)});
    wr(8'h1C, 32'h7);
    chk("irq clear", {31'h0, irq}, 32'h0);
    rd_chk("pc", 8'h04, {12'h0, pc_e});
    for (int i = 0; i < 14; i++) begin
      rd_chk("m reg", 8'(8'h40 + 4 * i), mm[i]);
    end
    rd_chk("v flag", 8'h24, {31'h0, v_e});
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    rst = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    pc_e = 20'h0;
    pb_lo = 20'h0;
    pb_hi = 20'hFFFFF;
    sec_lo = 20'h0;
    sec_hi = 20'hFFFFF;
    loop_e = 1'b0;
    v_e = 1'b0;
    mask_e = 3'h0;
    for (int i = 0; i < 14; i++) mm[i] = 32'h0;
    void'($urandom(32'h299E56A7));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values
    rd_chk("pb hi", 8'h0C, 32'h000FFFFF);
    rd_chk("sec hi", 8'h14, 32'h000FFFFF);
    rd_chk("status", 8'h1C, 32'h0);
    rd_chk("flags", 8'h24, 32'h0);
    rd_chk("pc", 8'h04, 32'h0);
    rd_chk("m reg", 8'h54, 32'h0);
    // Unmapped read and read-only write are refused
    axr(8'h30, d, r);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    axw(8'h24, 32'h3, r);
    chk("ro resp", {30'h0, r}, 32'h2);
    // Block, section, pc and mask
    pb_lo = 20'h00010;
    pb_hi = 20'h3FFFF;
    sec_lo = 20'h02000;
    sec_hi = 20'h02FFF;
    pc_e = 20'h02100;
    mask_e = 3'b101;
    wr(8'h08, {12'h0, pb_lo});
    wr(8'h0C, {12'h0, pb_hi});
    wr(8'h10, {12'h0, sec_lo});
    wr(8'h14, {12'h0, sec_hi});
    wr(8'h04, {12'h0, pc_e});
    wr(8'h20, {29'h0, mask_e});
    for (int i = 0; i < 14; i++) setm(i, $urandom());
    setm(3, 32'h00000123);
    // Transfers of control, edges of block and section
    exec(4'h1, 4'h0, 4'h0, 20'h02400);
    exec(4'h1, 4'h0, 4'h3, 20'h02400);
    exec(4'h1, 4'h0, 4'h0, 20'h40000);
    exec(4'h1, 4'h0, 4'h0, 20'h0000F);
    exec(4'h2, 4'h5, 4'h0, 20'h30000);
    exec(4'h2, 4'h0, 4'h0, 20'h02010);
    exec(4'h3, 4'h9, 4'h0, 20'h02FFF);
    exec(4'h3, 4'h9, 4'h0, 20'h03000);
    exec(4'h2, 4'h4, 4'h0, 20'h40000);
    exec(4'h7, 4'h5, 4'h0, 20'h00002);
    exec(4'h7, 4'h0, 4'h0, 20'h00000);
    // Calls refused inside a hardware loop, jumps still run
    loop_e = 1'b1;
    wr(8'h18, 32'h1);
    exec(4'h2, 4'h6, 4'h0, 20'h02200);
    exec(4'h3, 4'h6, 4'h0, 20'h02200);
    exec(4'h1, 4'h0, 4'h0, 20'h02200);
    loop_e = 1'b0;
    wr(8'h18, 32'h0);
    // Multiply corners around the overflow test
    setm(1, 32'h80000000);
    setm(2, 32'h80000000);
    exec(4'h5, 4'h1, 4'h2, 20'h0);
    setm(1, 32'hFFFFFFFF);
    setm(2, 32'h00000005);
    exec(4'h5, 4'h1, 4'h2, 20'h0);
    setm(1, 32'h40000000);
    setm(2, 32'h00000002);
    exec(4'h5, 4'h1, 4'h2, 20'h0);
    setm(4, 32'h7FFFFFFF);
    setm(7, 32'hFFFFFFFE);
    exec(4'h6, 4'h4, 4'h7, 20'h0);
    exec(4'h6, 4'h0, 4'h7, 20'h0);
    exec(4'h6, 4'hD, 4'hD, 20'h0);
    exec(4'h4, 4'h7, 4'h7, 20'h0);
    // Unknown code and a select past the last register are refused
    exec(4'h0, 4'h1, 4'h2, 20'h02400);
    exec(4'h4, 4'hE, 4'h2, 20'h0);
    // Random mix of all operations
    for (int n = 0; n < 40; n++) begin
      setm($urandom_range(13, 0), $urandom());
      mask_e = 3'($urandom());
      wr(8'h20, {29'h0, mask_e});
      loop_e = ($urandom_range(3, 0) == 0);
      wr(8'h18, {31'h0, loop_e});
      exec(4'($urandom_range(7, 1)), 4'($urandom_range(13, 0)), 4'($urandom_range(13, 0)),
           20'($urandom_range(32'h4FFFF, 0)));
    end
    test_done();
  end
endmodule
